// *** logic/program_flash_access_control.sv ***
// Program and data flash access control with boot mode selection
`timescale 1ns/10ps
module program_flash_access_control
  import flash_access_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_boot_select_strobe_pin_n,
  input wire logic i_parallel_mode,
  input wire logic [7:0] i_port_zero,
  input wire logic [7:0] i_port_one,
  input wire logic [7:0] i_port_two,
  input wire logic [7:0] i_port_three,
  input wire logic i_latch_strobe,
  input wire logic i_serial_valid,
  input wire logic [15:0] i_serial_addr,
  input wire logic [7:0] i_serial_data,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  output logic o_fetch_hit,
  output logic [15:0] o_start_vector,
  output logic [1:0] o_boot_mode,
  output logic o_prog_we,
  output logic o_prog_erase,
  output logic [15:0] o_prog_addr,
  output logic [7:0] o_prog_wdata,
  output logic o_data_we,
  output logic o_data_erase,
  output logic [11:0] o_data_addr,
  output logic [7:0] o_data_wdata,
  output logic o_busy
);

  logic rewrite_bit;
  // Options start erased, as on a blank part, and never see the core reset
  logic boot_opt_nv = 1'b0;
  logic safe_opt_nv = 1'b0;
  logic [7:0] page_high;
  logic [7:0] page_low;
  logic [7:0] status;
  logic [7:0] ram_mem [0:EXTENDED_RAM_BYTES-1];
  logic [7:0] data_hold [0:3];
  copy_state_t copy_state;
  logic [7:0] copy_idx;
  logic boot_caught;
  logic rewrite_mode;
  logic [7:0] next_rdata;

  // Decode of register strobes
  wire wr_cmd = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_FLASH_CMD);
  wire wr_page_h = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_PAGE_HIGH);
  wire wr_page_l = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_PAGE_LOW);
  wire wr_mode = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_MODE);
  wire wr_data = i_clk_en && i_reg_wr && (i_reg_addr[3:2] == ADDR_DATA0[3:2]);
  wire wr_ram = i_clk_en && i_reg_wr && (i_reg_addr == 4'hf);
  wire safe_mode = safe_opt_nv;
  wire boot_opt = boot_opt_nv;
  wire in_serial = (o_boot_mode == BOOT_SERIAL);
  wire in_parallel = (o_boot_mode == BOOT_PARALLEL);
  // Program page write allowed only in rewrite mode below the boot region
  wire page_ok = (page_high < PAGE_LIMIT);
  wire prog_cmd_ok = rewrite_mode && page_ok && (copy_state == ST_IDLE);
  wire start_copy = wr_cmd && (i_reg_wdata == CMD_WRITE) && prog_cmd_ok;
  wire erase_prog = wr_cmd && (i_reg_wdata == CMD_ERASE_PROG_PAGE) && prog_cmd_ok;
  wire data_cmd = wr_cmd && !rewrite_mode && (copy_state == ST_IDLE);
  wire data_write = data_cmd && (i_reg_wdata == CMD_WRITE);
  wire data_erase = data_cmd && (i_reg_wdata == CMD_ERASE_PAGE);
  wire [11:0] data_page_addr = {page_high[1:0], page_low[7:0], 2'b00};
  // Serial download may target the whole 62 kB array
  wire serial_ok = in_serial && i_serial_valid && (i_serial_addr <= PROG_LIMIT);
  // Parallel programmer: port three selects, latch strobe writes
  wire par_prog = in_parallel && i_latch_strobe && (i_port_three[1:0] == 2'b01);
  wire par_erase = in_parallel && i_latch_strobe && (i_port_three[1:0] == 2'b10);
  wire [15:0] par_addr = {i_port_two, i_port_one};
  wire fetch_ok = i_fetch_req && (i_fetch_addr <= PROG_LIMIT);

  assign rewrite_mode = rewrite_bit && !in_serial && !in_parallel;

  // Boot mode caught once after reset release; safe mode blocks serial download
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      boot_caught <= 1'b0;
      o_boot_mode <= BOOT_NORMAL;
      o_start_vector <= RESET_VECTOR;
    end else if (i_clk_en && !boot_caught) begin
      boot_caught <= 1'b1;
      if (i_parallel_mode) begin
        o_boot_mode <= BOOT_PARALLEL;
      end else if (!i_boot_select_strobe_pin_n && !safe_mode) begin
        o_boot_mode <= BOOT_SERIAL;
      end else begin
        o_boot_mode <= BOOT_NORMAL;
      end
      o_start_vector <= boot_opt ? BOOT_VECTOR : RESET_VECTOR;
    end
  end

  // Nonvolatile options: no reset, so the next boot can see them; downloaders only
  always_ff @(posedge i_core_clk) begin
    if (wr_mode && (in_serial || in_parallel)) begin
      boot_opt_nv <= i_reg_wdata[MODE_BOOT_BIT];
      safe_opt_nv <= i_reg_wdata[MODE_SAFE_BIT];
    end
  end

  // Rewrite request and page address registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rewrite_bit <= MODE_RESET[MODE_UFRM_BIT];
      page_high <= 8'h00;
      page_low <= 8'h00;
    end else begin
      if (wr_mode) begin
        rewrite_bit <= i_reg_wdata[MODE_UFRM_BIT];
      end
      if (wr_page_h) begin
        page_high <= i_reg_wdata;
      end
      if (wr_page_l) begin
        page_low <= i_reg_wdata;
      end
    end
  end

  // Staging RAM and data hold bytes have no reset
  always_ff @(posedge i_core_clk) begin
    if (wr_ram) begin
      ram_mem[page_low] <= i_reg_wdata;
    end
    if (wr_data) begin
      data_hold[i_reg_addr[1:0]] <= i_reg_wdata;
    end
  end

  // Page copy sequencer, one byte per enabled cycle
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      copy_state <= ST_IDLE;
      copy_idx <= 8'h00;
    end else if (i_clk_en) begin
      case (copy_state)
        ST_IDLE: begin
          copy_idx <= 8'h00;
          if (start_copy) begin
            copy_state <= ST_COPY;
          end
        end
        ST_COPY: begin
          copy_idx <= copy_idx + 8'h01;
          if (copy_idx == 8'hff) begin
            copy_state <= ST_DONE;
          end
        end
        ST_DONE: copy_state <= ST_IDLE;
        default: copy_state <= ST_IDLE;
      endcase
    end
  end

  // Program flash port: copy, erase, serial or parallel, else quiet
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prog_we <= 1'b0;
      o_prog_erase <= 1'b0;
      o_prog_addr <= 16'h0000;
      o_prog_wdata <= 8'h00;
    end else if (i_clk_en) begin
      o_prog_we <= 1'b0;
      o_prog_erase <= 1'b0;
      if (copy_state == ST_COPY) begin
        o_prog_we <= 1'b1;
        o_prog_addr <= {page_high, copy_idx};
        o_prog_wdata <= ram_mem[copy_idx];
      end else if (erase_prog) begin
        o_prog_erase <= 1'b1;
        o_prog_addr <= {page_high, 8'h00};
      end else if (serial_ok) begin
        o_prog_we <= 1'b1;
        o_prog_addr <= i_serial_addr;
        o_prog_wdata <= i_serial_data;
      end else if ((par_prog || par_erase) && (par_addr <= PROG_LIMIT)) begin
        o_prog_we <= par_prog;
        o_prog_erase <= par_erase;
        o_prog_addr <= par_addr;
        o_prog_wdata <= i_port_zero;
      end
    end
  end

  // Data flash port, byte program of hold byte 0 or page erase
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data_we <= 1'b0;
      o_data_erase <= 1'b0;
      o_data_addr <= 12'h000;
      o_data_wdata <= 8'h00;
    end else if (i_clk_en) begin
      o_data_we <= data_write;
      o_data_erase <= data_erase;
      if (data_write || data_erase) begin
        o_data_addr <= data_page_addr;
        o_data_wdata <= data_hold[0];
      end
    end
  end

  // Status: sticky refusal flag, set wins over clear
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      status <= STATUS_RESET;
      o_fetch_hit <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_fetch_hit <= fetch_ok;
      o_busy <= (copy_state != ST_IDLE) || start_copy;
      if (wr_cmd && !(start_copy || erase_prog || data_write || data_erase)) begin
        status[0] <= 1'b1;
      end else if (i_reg_wr && i_reg_addr == ADDR_STATUS) begin
        status[0] <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_rdata = 8'h00;
    case (i_reg_addr)
      ADDR_PAGE_HIGH: next_rdata = page_high;
      ADDR_PAGE_LOW: next_rdata = page_low;
      ADDR_MODE: next_rdata = {5'h00, safe_opt_nv, boot_opt_nv, rewrite_bit};
      ADDR_STATUS: next_rdata = {status[7:4], o_boot_mode, o_busy, status[0]};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_reg_rdata <= i_reg_rd ? next_rdata : 8'h00;
    end
  end

  property p_user_no_boot;
    @(posedge i_core_clk) disable iff (i_reset)
      (o_prog_we && copy_state == ST_COPY) |-> (o_prog_addr <= USER_LIMIT);
  endproperty
  a_user_no_boot: assert property (p_user_no_boot) else $error("copy hit boot region");

  property p_no_write_outside;
    @(posedge i_core_clk) disable iff (i_reset)
      (i_clk_en && !rewrite_mode && !in_serial && !in_parallel) |=> !o_prog_we;
  endproperty
  a_no_write_outside: assert property (p_no_write_outside) else $error("write out of mode");

  property p_copy_len;
    @(posedge i_core_clk) disable iff (i_reset)
      $rose(copy_state == ST_COPY) |-> (copy_state == ST_COPY)[*8];
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy ended early");

  property p_serial_range;
    @(posedge i_core_clk) disable iff (i_reset)
      (o_prog_we && in_serial) |-> (o_prog_addr <= PROG_LIMIT);
  endproperty
  a_serial_range: assert property (p_serial_range) else $error("serial out of array");

  property p_safe;
    @(posedge i_core_clk) disable iff (i_reset)
      (!boot_caught && i_clk_en && safe_mode && !i_parallel_mode) |=> !in_serial;
  endproperty
  a_safe: assert property (p_safe) else $error("safe mode entered download");

  property p_data_erase;
    @(posedge i_core_clk) disable iff (i_reset)
      o_data_erase |-> (o_data_addr[1:0] == 2'b00);
  endproperty
  a_data_erase: assert property (p_data_erase) else $error("erase not page aligned");

  property p_vector;
    @(posedge i_core_clk) disable iff (i_reset)
      $rose(boot_caught) |-> (o_start_vector == (boot_opt ? BOOT_VECTOR : RESET_VECTOR));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong start vector");

  property p_fetch;
    @(posedge i_core_clk) disable iff (i_reset)
      (i_clk_en && i_fetch_req && i_fetch_addr > PROG_LIMIT) |=> !o_fetch_hit;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch above array hit");

  property p_boot_top_locked;
    @(posedge i_core_clk) disable iff (i_reset)
      ((o_prog_we || o_prog_erase) && !in_serial && !in_parallel) |-> (o_prog_addr <= USER_LIMIT);
  endproperty
  a_boot_top_locked: assert property (p_boot_top_locked) else $error("user hit top region");

  property p_refused_flag;
    @(posedge i_core_clk) disable iff (i_reset)
      (wr_cmd && i_reg_wdata == CMD_ERASE_PROG_PAGE && !rewrite_mode && !in_parallel)
        |=> (status[0] && !o_prog_erase);
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("illegal erase not refused");

  property p_data_locked;
    @(posedge i_core_clk) disable iff (i_reset)
      (wr_cmd && rewrite_mode) |=> (!o_data_we && !o_data_erase);
  endproperty
  a_data_locked: assert property (p_data_locked) else $error("data flash hit in rewrite");

  property p_busy;
    @(posedge i_core_clk) disable iff (i_reset)
      start_copy |=> o_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("copy start not busy");

  property p_parallel_boot;
    @(posedge i_core_clk) disable iff (i_reset)
      (!boot_caught && i_clk_en && i_parallel_mode) |=> in_parallel;
  endproperty
  a_parallel_boot: assert property (p_parallel_boot) else $error("parallel strap missed");

  c_copy: cover property (@(posedge i_core_clk) copy_state == ST_DONE);
  c_serial: cover property (@(posedge i_core_clk) o_prog_we && in_serial);
  c_data: cover property (@(posedge i_core_clk) o_data_erase);
  c_safe: cover property (@(posedge i_core_clk) $rose(boot_caught) && safe_mode && !in_serial);
  c_parallel: cover property (@(posedge i_core_clk) o_prog_erase && in_parallel);

endmodule

// *** logic/flash_access_pkg.sv ***
// Constants for the program flash access control block
package flash_access_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] PROG_BASE = 16'h0000;
  localparam logic [15:0] PROG_LIMIT = 16'hf7ff;
  localparam logic [15:0] USER_LIMIT = 16'hdfff;
  localparam logic [15:0] BOOT_VECTOR = 16'he000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PAGE_LIMIT = 8'he0;
  localparam logic [11:0] DATA_LIMIT = 12'hfff;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_PROG_PAGE = 8'h06;
  localparam int EXTENDED_RAM_BYTES = 256;
  localparam logic [3:0] ADDR_FLASH_CMD = 4'h0;
  localparam logic [3:0] ADDR_PAGE_HIGH = 4'h1;
  localparam logic [3:0] ADDR_PAGE_LOW = 4'h2;
  localparam logic [3:0] ADDR_MODE = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA0 = 4'h8;
  localparam int MODE_UFRM_BIT = 0;
  localparam int MODE_BOOT_BIT = 1;
  localparam int MODE_SAFE_BIT = 2;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_DONE = 2'b11
  } copy_state_t;
  typedef enum logic [1:0] {
    BOOT_NORMAL = 2'b00,
    BOOT_SERIAL = 2'b01,
    BOOT_PARALLEL = 2'b11
  } boot_mode_t;
endpackage

// *** testbench/download_host_model.sv ***
// Serial download host and parallel programmer seen from the device pins
`timescale 1ns/10ps
module download_host_model (
  input wire logic i_core_clk,
  output logic o_valid,
  output logic [15:0] o_addr,
  output logic [7:0] o_data,
  output logic [7:0] o_port_zero,
  output logic [7:0] o_port_one,
  output logic [7:0] o_port_two,
  output logic [7:0] o_port_three,
  output logic o_strobe
);
  initial begin
    o_valid = 1'b0;
    o_addr = 16'h0000;
    o_data = 8'h00;
    {o_port_zero, o_port_one, o_port_two, o_port_three} = 32'h0000_0000;
    o_strobe = 1'b0;
  end

  // One byte over the serial link; lines show inverted junk once released
  task serial_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_addr <= a;
    o_data <= d;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_data <= ~d;
  endtask

  // Programmer bus cycle: ports carry data/address, latch strobe writes
  task par_cycle(input logic [15:0] a, input logic [7:0] d, input logic [7:0] cfg);
    @(posedge i_core_clk);
    o_port_zero <= d;
    {o_port_two, o_port_one} <= a;
    o_port_three <= cfg;
    o_strobe <= 1'b1;
    @(posedge i_core_clk);
    o_strobe <= 1'b0;
    o_port_zero <= ~d;
    {o_port_two, o_port_one} <= ~a;
    o_port_three <= ~cfg;
  endtask
endmodule

// *** testbench/program_flash_access_control_bench.sv ***
// Self-checking bench for the program flash access control block
`timescale 1ns/10ps
module program_flash_access_control_bench;
  import flash_access_pkg::*;
  logic i_core_clk, i_reset, i_clk_en, i_reg_wr, i_reg_rd, i_pin_n, i_par, i_fetch_req;
  logic [3:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, v, d_first;
  logic [15:0] i_fetch_addr, o_start_vector, o_prog_addr, a_first, a_last;
  logic [1:0] o_boot_mode;
  logic o_fetch_hit, o_prog_we, o_prog_erase, o_data_we, o_data_erase, o_busy;
  logic s_valid, strobe;
  logic [15:0] s_addr;
  logic [7:0] s_data, p0, p1, p2, p3, o_prog_wdata, o_data_wdata;
  logic [11:0] o_data_addr;
  int failures, checked, n_we, n_er, n_dwe, n_der;
  // Fetch rows: address beside expected hit
  logic [16:0] rows [4] = '{{16'h0000, 1'b1}, {16'hf7ff, 1'b1}, {16'hf800, 1'b0}, {16'hffff, 1'b0}};

  program_flash_access_control u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_boot_select_strobe_pin_n(i_pin_n), .i_parallel_mode(i_par), .i_port_zero(p0),
    .i_port_one(p1), .i_port_two(p2), .i_port_three(p3), .i_latch_strobe(strobe),
    .i_serial_valid(s_valid), .i_serial_addr(s_addr), .i_serial_data(s_data),
    .i_fetch_req(i_fetch_req), .i_fetch_addr(i_fetch_addr), .o_fetch_hit(o_fetch_hit),
    .o_start_vector(o_start_vector), .o_boot_mode(o_boot_mode), .o_prog_we(o_prog_we),
    .o_prog_erase(o_prog_erase), .o_prog_addr(o_prog_addr), .o_prog_wdata(o_prog_wdata),
    .o_data_we(o_data_we), .o_data_erase(o_data_erase), .o_data_addr(o_data_addr),
    .o_data_wdata(o_data_wdata), .o_busy(o_busy));
  download_host_model u_host (.i_core_clk(i_core_clk), .o_valid(s_valid), .o_addr(s_addr),
    .o_data(s_data), .o_port_zero(p0), .o_port_one(p1), .o_port_two(p2), .o_port_three(p3),
    .o_strobe(strobe));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Pulse counters; the first and last address of a burst show its span
  always @(posedge i_core_clk) begin
    if (o_prog_we === 1'b1) begin
      if (n_we == 0) {a_first, d_first} = {o_prog_addr, o_prog_wdata};
      n_we++;
      a_last = o_prog_addr;
    end
    if (o_data_we === 1'b1) {n_dwe, a_last, d_first} = {n_dwe + 1, 4'h0, o_data_addr, o_data_wdata};
    if (o_prog_erase === 1'b1) n_er++;
    if (o_data_erase === 1'b1) n_der++;
  end

  task clr;
    {n_we, n_er, n_dwe, n_der} = '0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    {i_reg_addr, i_reg_rd} <= {a, 1'b1};
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  // Straps are held through reset, sampled on the first edge after release
  task boot(input logic pin_n, input logic par);
    @(posedge i_core_clk);
    {i_pin_n, i_par, i_reset} <= {pin_n, par, 1'b1};
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    idle(3);
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd, i_fetch_req, i_fetch_addr} = '0;
    {failures, checked, i_clk_en, i_reset} = {32'd0, 32'd0, 1'b1, 1'b1};
    clr();
    boot(1'b1, 1'b0);
    check("boot_mode", 16'h0000, o_boot_mode);
    check("start_vector", 16'h0000, o_start_vector);
    foreach (rows[i]) begin
      @(posedge i_core_clk);
      {i_fetch_req, i_fetch_addr} <= {1'b1, rows[i][16:1]};
      idle(1);
      check("fetch_hit", rows[i][0], o_fetch_hit);
    end
    i_fetch_req <= 1'b0;
    wr(4'h6, 8'hff);
    wr(ADDR_MODE, 8'h06);
    rd(ADDR_MODE, v);
    check("mode", 16'h0000, v);
    $display("test reset done");
    // Data flash: page erase then a byte write at page 5
    // Clock enable low freezes the block, so a command is not taken
    @(posedge i_core_clk);
    i_clk_en <= 1'b0;
    wr(ADDR_FLASH_CMD, CMD_ERASE_PAGE);
    idle(2);
    check("frozen_erase", 16'h0000, n_der);
    @(posedge i_core_clk);
    i_clk_en <= 1'b1;
    wr(ADDR_PAGE_HIGH, 8'h00);
    wr(ADDR_PAGE_LOW, 8'h05);
    wr(ADDR_DATA0, 8'h3c);
    wr(ADDR_FLASH_CMD, CMD_ERASE_PAGE);
    wr(ADDR_FLASH_CMD, CMD_WRITE);
    idle(5);
    check("data_erase", 16'h0001, n_der);
    check("data_we", 16'h0001, n_dwe);
    check("data_addr", 16'h0014, a_last);
    check("data_byte", 16'h003c, d_first);
    // Program erase outside rewrite mode is refused
    clr();
    wr(ADDR_FLASH_CMD, CMD_ERASE_PROG_PAGE);
    idle(3);
    rd(ADDR_STATUS, v);
    check("prog_erase", 16'h0000, n_er);
    check("status", 16'h0001, v);
    wr(ADDR_STATUS, 8'h00);
    // Rewrite mode: boot page refused, top user page accepted
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_PAGE_HIGH, 8'he0);
    wr(ADDR_FLASH_CMD, CMD_ERASE_PROG_PAGE);
    idle(3);
    rd(ADDR_STATUS, v);
    check("prog_erase", 16'h0000, n_er);
    check("status", 16'h0001, v);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_PAGE_LOW, 8'h00);
    wr(4'hf, 8'ha5);
    wr(ADDR_PAGE_HIGH, 8'hdf);
    wr(ADDR_FLASH_CMD, CMD_ERASE_PROG_PAGE);
    idle(3);
    check("prog_erase", 16'h0001, n_er);
    wr(ADDR_FLASH_CMD, CMD_WRITE);
    rd(ADDR_STATUS, v);
    check("status_busy", 16'h0002, v);
    idle(270);
    check("copy_count", 16'h0100, n_we);
    check("copy_first", 16'hdf00, a_first);
    check("copy_last", 16'hdfff, a_last);
    check("copy_byte", 16'h00a5, d_first);
    $display("test rewrite done");
    // Serial download may write the boot region and set the boot option
    boot(1'b0, 1'b0);
    check("boot_mode", 16'h0001, o_boot_mode);
    clr();
    u_host.serial_byte(16'hf000, 8'h5a);
    idle(3);
    check("serial_we", 16'h0001, n_we);
    check("serial_addr", 16'hf000, a_first);
    check("serial_byte", 16'h005a, d_first);
    rd(ADDR_STATUS, v);
    check("status_mode", 16'h0004, v);
    // Boot and safe options set by the downloader outlive the next reset
    wr(ADDR_MODE, 8'h06);
    rd(ADDR_MODE, v);
    check("mode", 16'h0006, v);
    boot(1'b0, 1'b0);
    check("boot_mode", 16'h0000, o_boot_mode);
    check("start_vector", BOOT_VECTOR, o_start_vector);
    $display("test serial done");
    // Parallel programmer: program and erase selected by port three
    boot(1'b1, 1'b1);
    check("boot_mode", 16'h0003, o_boot_mode);
    clr();
    u_host.par_cycle(16'hf100, 8'h77, 8'h01);
    u_host.par_cycle(16'hf100, 8'h00, 8'h02);
    idle(3);
    check("par_we", 16'h0001, n_we);
    check("par_addr", 16'hf100, a_first);
    check("par_byte", 16'h0077, d_first);
    check("par_erase", 16'h0001, n_er);
    $display("test parallel done");
    end_of_test();
  end

  // Watchdog well beyond the roughly 400 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge i_core_clk);
    failures++;
    end_of_test();
  end
endmodule
